// ### rtl/temp_alert_pkg.sv
package temp_alert_pkg;

    // ------------------------------------------------------------
    // configuration word layout
    // ------------------------------------------------------------
    localparam int unsigned RATE_MSB     = 15;
    localparam int unsigned RATE_LSB     = 13;
    localparam int unsigned ONE_SHOT_BIT = 12;
    localparam int unsigned SHUTDOWN_BIT = 11;
    localparam int unsigned HI1_BIT      = 10;
    localparam int unsigned LO1_BIT      = 9;
    localparam int unsigned MODE1_BIT    = 8;
    localparam int unsigned ALERT_POLARITY1_BIT     = 7;
    localparam int unsigned HI2_BIT      = 6;
    localparam int unsigned LO2_BIT      = 5;
    localparam int unsigned MODE2_BIT    = 4;
    localparam int unsigned POL2_BIT     = 3;

    // ------------------------------------------------------------
    // widths and reset values
    // ------------------------------------------------------------
    localparam int unsigned CFG_W        = 16;
    localparam int unsigned TEMP_W       = 14;
    localparam logic [2:0]  RATE_RESET   = 3'h5;
    localparam logic [15:0] CONFIG_RESET = 16'hA000;

    // ------------------------------------------------------------
    // timing: clock period and conversion periods
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned NS_PER_MS     = 1000000;
    localparam int unsigned CYCLES_PER_MS = NS_PER_MS / CLK_PERIOD_NS;
    localparam int unsigned PERIOD_MS [8] = '{15, 50, 100, 250, 500, 1000, 4000, 16000};

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef logic signed [TEMP_W-1:0] temp_t;

    typedef struct packed {
        logic [2:0] rate;
        logic       shutdown;
        logic       mode1;
        logic       alert_polarity1;
        logic       mode2;
        logic       pol2;
    } cfg_t;

    typedef struct packed {
        temp_t high;
        temp_t low;
    } limits_t;

endpackage

// ### rtl/limit_channel.sv
`timescale 1ns/1ps

module limit_channel
    import temp_alert_pkg::*;
(
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    srst,
    // mode and events
    input  wire logic                    hyst,
    input  wire logic                    done,
    input  wire logic                    rd_clr,
    // result and limits
    input  wire temp_alert_pkg::temp_t   result,
    input  wire temp_alert_pkg::limits_t lim,
    // flags
    output logic                         hi_flag,
    output logic                         lo_flag
);
    import temp_alert_pkg::*;

    logic hi_q;
    logic lo_q;
    logic above;
    logic below;

    // ------------------------------------------------------------
    // comparisons against the limits
    // ------------------------------------------------------------
    assign above = result > lim.high;
    assign below = result < lim.low;

    // high flag: sticky window or threshold with hysteresis
    always_ff @(posedge clk)
    begin
        if (srst)
            hi_q <= 1'b0;
        else if (hyst)
        begin
            if (done && above)
                hi_q <= 1'b1;
            else if (done && below)
                hi_q <= 1'b0;
        end
        else
            hi_q <= (done && above) || (hi_q && !rd_clr);
    end

    // low flag: only used in window mode
    always_ff @(posedge clk)
    begin
        if (srst || hyst)
            lo_q <= 1'b0;
        else
            lo_q <= (done && below) || (lo_q && !rd_clr);
    end

    assign hi_flag = hi_q;
    assign lo_flag = lo_q && !hyst;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_window_set: assert property (@(posedge clk) disable iff (srst)
        !hyst && done && above && below == 1'b0 |=> hi_flag)
        else $error("window high flag not set above limit");

    a_read_clear: assert property (@(posedge clk) disable iff (srst)
        !hyst && rd_clr && !done ##1 !hyst |-> !hi_flag && !lo_flag)
        else $error("window flags not cleared by read");

    a_hyst_hold: assert property (@(posedge clk) disable iff (srst)
        hyst && !done ##1 hyst |-> $stable(hi_flag))
        else $error("hysteresis flag changed outside conversion end");

    a_hyst_release: assert property (@(posedge clk) disable iff (srst)
        hyst && done && below && !above |=> !hi_flag)
        else $error("hysteresis flag not released below low limit");

    a_hyst_low_zero: assert property (@(posedge clk) disable iff (srst)
        hyst |-> !lo_flag)
        else $error("low flag nonzero in hysteresis mode");

endmodule // limit_channel

// ### rtl/temp_sensor_config_alert.sv
// Summary of operation
// - rate field 15:13, reset 5h, sets continuous period; one-shot ignores it
// - writing one-shot 1 while shutdown 1 starts exactly one conversion
// - after the one-shot conversion, return to shutdown and stay idle
// - one-shot bit always reads back as zero
// - shutdown bit: 0 continuous conversions, 1 idle except one-shot requests
// - channel 1 high flag shows result above channel 1 high limit
// - channel 1 low flag shows result below low limit; zero in hysteresis
// - channel 1 window mode compares each result against high and low limits
// - window mode flags stay set until a configuration read clears them
// - channel 1 hysteresis: set above high limit, clear below low limit
// - hysteresis flags change only at conversion end; reads do not clear
// - polarity bit 7 makes alert pin active low at 0, high at 1
// - channel 2 high flag shows result above channel 2 high limit
// - channel 2 low flag below low limit in window; zero in hysteresis
// - channel 2 flags behave like channel 1 with own mode and limits; they and pol2 drive no alert pin
// - any configuration write aborts conversion and applies new settings at once
`timescale 1ns/1ps

module temp_sensor_config_alert
    import temp_alert_pkg::*;
#(
    parameter int unsigned CYCLES_MS = temp_alert_pkg::CYCLES_PER_MS
)
(
    // clock and reset
    input  wire logic                    CLK_SYS,
    input  wire logic                    SRST,
    // configuration register access
    input  wire logic                    REG_WR,
    input  wire logic [15:0]             REG_WDATA,
    input  wire logic                    REG_RD,
    output logic      [15:0]             REG_RDATA,
    // converter handshake
    output logic                         CONV_START,
    output logic                         CONV_ABORT,
    output logic                         CONV_BUSY,
    input  wire logic                    CONV_DONE,
    input  wire temp_alert_pkg::temp_t   CONV_RESULT,
    // limits
    input  wire temp_alert_pkg::limits_t LIMITS1,
    input  wire temp_alert_pkg::limits_t LIMITS2,
    // alert pin
    output logic                         ALERT_PIN1
);
    import temp_alert_pkg::*;

    typedef enum logic [1:0] {
        ST_SHUTDOWN,
        ST_CONVERT,
        ST_WAIT
    } state_t;

    state_t      state_q;
    cfg_t        cfg_q;
    logic        one_shot_q;
    logic        start_q;
    logic        abort_q;
    logic [31:0] tmr_q;
    logic [31:0] period_cyc;
    logic [15:0] rdata_q;
    logic        alert_q;
    logic        done_ok;
    logic        hi1;
    logic        lo1;
    logic        hi2;
    logic        lo2;
    logic        alert_any;

    // ------------------------------------------------------------
    // configuration register
    // ------------------------------------------------------------

    // writable fields, reset to the documented defaults
    always_ff @(posedge CLK_SYS)
    begin
        if (SRST)
        begin
            cfg_q          <= '0;
            cfg_q.rate     <= RATE_RESET;
        end
        else if (REG_WR)
        begin
            cfg_q.rate     <= REG_WDATA[RATE_MSB:RATE_LSB];
            cfg_q.shutdown <= REG_WDATA[SHUTDOWN_BIT];
            cfg_q.mode1    <= REG_WDATA[MODE1_BIT];
            cfg_q.alert_polarity1     <= REG_WDATA[ALERT_POLARITY1_BIT];
            cfg_q.mode2    <= REG_WDATA[MODE2_BIT];
            cfg_q.pol2     <= REG_WDATA[POL2_BIT];
        end
    end

    // read data, captured on the read strobe
    always_ff @(posedge CLK_SYS)
    begin
        if (SRST)
            rdata_q <= CONFIG_RESET;
        else if (REG_RD)
        begin
            rdata_q                        <= '0;
            rdata_q[RATE_MSB:RATE_LSB]     <= cfg_q.rate;
            rdata_q[ONE_SHOT_BIT]          <= 1'b0;
            rdata_q[SHUTDOWN_BIT]          <= cfg_q.shutdown;
            rdata_q[HI1_BIT]               <= hi1;
            rdata_q[LO1_BIT]               <= lo1;
            rdata_q[MODE1_BIT]             <= cfg_q.mode1;
            rdata_q[ALERT_POLARITY1_BIT]              <= cfg_q.alert_polarity1;
            rdata_q[HI2_BIT]               <= hi2;
            rdata_q[LO2_BIT]               <= lo2;
            rdata_q[MODE2_BIT]             <= cfg_q.mode2;
            rdata_q[POL2_BIT]              <= cfg_q.pol2;
        end
    end

    assign REG_RDATA = rdata_q;

    // ------------------------------------------------------------
    // conversion sequencing
    // ------------------------------------------------------------

    // period of the selected rate in clock cycles
    always_comb
        period_cyc = 32'(64'(PERIOD_MS[cfg_q.rate]) * 64'(CYCLES_MS));

    // a finished conversion counts only if no write aborted it
    assign done_ok = CONV_DONE && (state_q == ST_CONVERT) && !REG_WR;

    // state, start and abort pulses, period timer
    always_ff @(posedge CLK_SYS)
    begin
        if (SRST)
        begin
            state_q    <= ST_CONVERT;
            one_shot_q <= 1'b0;
            start_q    <= 1'b1;
            abort_q    <= 1'b0;
            tmr_q      <= 32'(64'(PERIOD_MS[RATE_RESET]) * 64'(CYCLES_MS)) - 32'h0000_0001;
        end
        else
        begin
            start_q <= 1'b0;
            abort_q <= 1'b0;
            if (tmr_q != 32'h0000_0000)
                tmr_q <= tmr_q - 32'h0000_0001;
            if (REG_WR)
            begin
                abort_q <= (state_q == ST_CONVERT);
                if (!REG_WDATA[SHUTDOWN_BIT])
                begin
                    // continuous: restart at the new rate
                    state_q    <= ST_CONVERT;
                    one_shot_q <= 1'b0;
                    start_q    <= 1'b1;
                    tmr_q      <= 32'(64'(PERIOD_MS[REG_WDATA[RATE_MSB:RATE_LSB]])
                                  * 64'(CYCLES_MS)) - 32'h0000_0001;
                end
                else if (REG_WDATA[ONE_SHOT_BIT])
                begin
                    // single conversion from shutdown
                    state_q    <= ST_CONVERT;
                    one_shot_q <= 1'b1;
                    start_q    <= 1'b1;
                end
                else
                begin
                    state_q    <= ST_SHUTDOWN;
                    one_shot_q <= 1'b0;
                end
            end
            else
            begin
                unique case (state_q)
                    ST_SHUTDOWN: ;
                    ST_CONVERT:
                    begin
                        if (done_ok && one_shot_q)
                        begin
                            state_q    <= ST_SHUTDOWN;
                            one_shot_q <= 1'b0;
                        end
                        else if (done_ok)
                            state_q <= ST_WAIT;
                    end
                    ST_WAIT:
                    begin
                        if (tmr_q == 32'h0000_0000)
                        begin
                            state_q <= ST_CONVERT;
                            start_q <= 1'b1;
                            tmr_q   <= period_cyc - 32'h0000_0001;
                        end
                    end
                endcase
            end
        end
    end

    assign CONV_START = start_q;
    assign CONV_ABORT = abort_q;
    assign CONV_BUSY  = (state_q == ST_CONVERT);

    // ------------------------------------------------------------
    // limit channels
    // ------------------------------------------------------------

    // channel 1
    limit_channel u_chan1 (
        .clk     (CLK_SYS),
        .srst    (SRST),
        .hyst    (cfg_q.mode1),
        .done    (done_ok),
        .rd_clr  (REG_RD),
        .result  (CONV_RESULT),
        .lim     (LIMITS1),
        .hi_flag (hi1),
        .lo_flag (lo1)
    );

    // channel 2, same behaviour with its own mode and limits
    limit_channel u_chan2 (
        .clk     (CLK_SYS),
        .srst    (SRST),
        .hyst    (cfg_q.mode2),
        .done    (done_ok),
        .rd_clr  (REG_RD),
        .result  (CONV_RESULT),
        .lim     (LIMITS2),
        .hi_flag (hi2),
        .lo_flag (lo2)
    );

    // ------------------------------------------------------------
    // alert pin
    // ------------------------------------------------------------

    // active level follows the polarity bit
    assign alert_any = hi1 || lo1;

    always_ff @(posedge CLK_SYS)
    begin
        if (SRST)
            alert_q <= 1'b1;                                    // idle high, active low
        else
            alert_q <= cfg_q.alert_polarity1 ? alert_any : !alert_any;
    end

    assign ALERT_PIN1 = alert_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_os_reads_zero: assert property (@(posedge CLK_SYS) disable iff (SRST)
        REG_RD |=> !REG_RDATA[ONE_SHOT_BIT])
        else $error("one-shot bit read back nonzero");

    a_write_abort: assert property (@(posedge CLK_SYS) disable iff (SRST)
        REG_WR && CONV_BUSY |=> CONV_ABORT)
        else $error("write did not abort running conversion");

    a_continuous_restart: assert property (@(posedge CLK_SYS) disable iff (SRST)
        REG_WR && !REG_WDATA[SHUTDOWN_BIT] |=> CONV_START && CONV_BUSY)
        else $error("continuous write did not restart conversion");

    a_oneshot_start: assert property (@(posedge CLK_SYS) disable iff (SRST)
        REG_WR && REG_WDATA[SHUTDOWN_BIT] && REG_WDATA[ONE_SHOT_BIT] |=> CONV_START)
        else $error("one-shot request did not start conversion");

    a_oneshot_return: assert property (@(posedge CLK_SYS) disable iff (SRST)
        done_ok && one_shot_q |=> state_q == ST_SHUTDOWN ##1 (!CONV_START || $past(REG_WR)))
        else $error("one-shot did not return to shutdown");

    a_shutdown_quiet: assert property (@(posedge CLK_SYS) disable iff (SRST)
        state_q == ST_SHUTDOWN && !REG_WR |=> !CONV_START)
        else $error("conversion started in shutdown");

    a_alert_level: assert property (@(posedge CLK_SYS) disable iff (SRST)
        ##1 ALERT_PIN1 == ($past(cfg_q.alert_polarity1) ~^ $past(alert_any)))
        else $error("alert pin level wrong for flags and polarity");

endmodule // temp_sensor_config_alert

// ### dv/tb_temp_sensor_config_alert.sv
`timescale 1ns/1ps

module tb_temp_sensor_config_alert;
    import temp_alert_pkg::*;

    // ------------------------------------------------------------
    // signals and counters
    // ------------------------------------------------------------
    localparam int CM = 2;          // shortened cycles per ms
    logic        CLK_SYS;
    logic        SRST;
    logic        REG_WR;
    logic [15:0] REG_WDATA;
    logic        REG_RD;
    logic [15:0] REG_RDATA;
    logic        CONV_START;
    logic        CONV_ABORT;
    logic        CONV_BUSY;
    logic        CONV_DONE;
    temp_t       CONV_RESULT;
    limits_t     LIMITS1;
    limits_t     LIMITS2;
    logic        ALERT_PIN1;
    logic        st;
    logic        ab;
    int          mismatches;
    int          n_tests;
    int          starts;
    int          s0;

    // ------------------------------------------------------------
    // device under test
    // ------------------------------------------------------------
    temp_sensor_config_alert #(.CYCLES_MS(CM)) dut (
        .CLK_SYS     (CLK_SYS),
        .SRST        (SRST),
        .REG_WR      (REG_WR),
        .REG_WDATA   (REG_WDATA),
        .REG_RD      (REG_RD),
        .REG_RDATA   (REG_RDATA),
        .CONV_START  (CONV_START),
        .CONV_ABORT  (CONV_ABORT),
        .CONV_BUSY   (CONV_BUSY),
        .CONV_DONE   (CONV_DONE),
        .CONV_RESULT (CONV_RESULT),
        .LIMITS1     (LIMITS1),
        .LIMITS2     (LIMITS2),
        .ALERT_PIN1      (ALERT_PIN1)
    );

    // clock and start pulse counter
    always #4 CLK_SYS = ~CLK_SYS;
    always @(posedge CLK_SYS) if (CONV_START === 1'b1) starts++;

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // write strobe, then capture start/abort pulses
    task automatic wr(input logic [15:0] d);
        @(posedge CLK_SYS);
        REG_WR    <= 1'b1;
        REG_WDATA <= d;
        @(posedge CLK_SYS);
        REG_WR <= 1'b0;
        #1;
        st = CONV_START;
        ab = CONV_ABORT;
    endtask

    // read strobe, data the cycle after
    task automatic rd(input logic [15:0] exp);
        @(posedge CLK_SYS);
        REG_RD <= 1'b1;
        @(posedge CLK_SYS);
        REG_RD <= 1'b0;
        #1;
        chk(REG_RDATA, exp);
    endtask

    // finish a conversion with the given result
    task automatic conv(input temp_t r);
        int n;
        n = 0;
        while (CONV_BUSY !== 1'b1 && n < 100)
        begin
            @(posedge CLK_SYS);
            #1;
            n++;
        end
        @(posedge CLK_SYS);
        CONV_DONE   <= 1'b1;
        CONV_RESULT <= r;
        @(posedge CLK_SYS);
        CONV_DONE <= 1'b0;
        repeat (3) @(posedge CLK_SYS);
        #1;
    endtask

    // cycles between two starts in continuous mode
    task automatic period(input int r);
        int n;
        wr({r[2:0], 13'h0000});
        chk(st, 1'b1);
        @(posedge CLK_SYS);
        CONV_DONE   <= 1'b1;
        CONV_RESULT <= 14'h0000;
        @(posedge CLK_SYS);
        CONV_DONE <= 1'b0;
        #1;
        n = 2;
        while (CONV_START !== 1'b1 && n < 40000)
        begin
            @(posedge CLK_SYS);
            #1;
            n++;
        end
        chk(n[15:0], 16'(PERIOD_MS[r] * CM));
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------
    initial
    begin
        #500000;                         // about 62k cycles; the tests need about 44k
        mismatches++;
        tally_and_finish();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        CLK_SYS = 1'b0; SRST = 1'b1; REG_WR = 1'b0; REG_WDATA = 16'h0000;
        REG_RD = 1'b0; CONV_DONE = 1'b0; CONV_RESULT = 14'h0000;
        mismatches = 0; n_tests = 0; starts = 0;
        LIMITS1 = {14'h0064, 14'h3F9C};  // +100 / -100
        LIMITS2 = {14'h0032, 14'h3FCE};  // +50 / -50
        repeat (6) @(posedge CLK_SYS);
        SRST <= 1'b0;
        rd(16'hA000);
        chk(ALERT_PIN1, 1'b1);
        // shutdown aborts the running conversion
        wr(16'h0800);
        chk(ab, 1'b1);
        chk(CONV_BUSY, 1'b0);
        rd(16'h0800);
        // one-shot, window mode, high flags
        wr(16'h1800);
        chk(st, 1'b1);
        rd(16'h0800);
        conv(14'h00C8);
        chk(CONV_BUSY, 1'b0);
        chk(ALERT_PIN1, 1'b0);
        rd(16'h0C40);
        rd(16'h0800);
        @(posedge CLK_SYS);
        #1;
        chk(ALERT_PIN1, 1'b1);
        s0 = starts;
        repeat (50) @(posedge CLK_SYS);
        chk(16'(starts - s0), 16'h0000);
        // low flags, then a result between the two high limits
        wr(16'h1800);
        conv(14'h3F38);
        chk(ALERT_PIN1, 1'b0);
        rd(16'h0A20);
        rd(16'h0800);
        wr(16'h1800);
        conv(14'h004B);
        rd(16'h0840);
        // hysteresis on both channels
        wr(16'h1910);
        conv(14'h00C8);
        rd(16'h0D50);
        rd(16'h0D50);
        chk(ALERT_PIN1, 1'b0);
        wr(16'h0990);
        repeat (2) @(posedge CLK_SYS);
        #1;
        chk(ALERT_PIN1, 1'b1);
        rd(16'h0DD0);
        wr(16'h1990);
        conv(14'h0000);
        rd(16'h0DD0);
        wr(16'h1990);
        conv(14'h3F38);
        rd(16'h0990);
        chk(ALERT_PIN1, 1'b0);
        // continuous periods for every rate code
        for (int r = 0; r < 8; r++)
            period(r);
        tally_and_finish();
    end

endmodule // tb_temp_sensor_config_alert
